// file: common/bus_packetizer_consts.svh
// Contract
// RL1 - format 1 channel word goes out as low half then high half
// RL2 - format 1 time stamp goes out as four halves, lowest first
// RL3 - format 1 data header goes out as three halves, lowest first
// RL4 - format 1 message words follow the header in bus order, command first
// RL5 - format 2 transaction is six 32-bit words in fixed order
// RL6 - several format 2 transactions may share one packet body
// RL7 - format 2 channel word holds the transaction count in all bits; code puts the 16-bit count in bits 15-0, bits 31-16 zero
// RL8 - packet closes only between whole transactions
// RL9 - each format 2 transaction is preceded by time stamp and data header
// RL10 - format 2 length field is always 24 bytes
// RL11 - format 2 status field reports errors seen on the transaction
// RL12 - each error bit is one when its error occurred, else zero
// RL13 - status bits: 15 error, 14 reset, 13 timeout, 6 status, 3 echo
// RL14 - format 2 stamp low word, high word, then length and status word
// RL15 - reserved bits of channel and status words are written zero
// RL16 - format 2 stamp holds 48-bit count, upper 16 bits zero
// RL17 - format 1 data header is block status, gap times, byte length
// RL18 - format 1 channel word: position code 31-30, count 23-0
// RL19 - each weapons-bus word is stored as two halves, sync and parity dropped
`ifndef BUS_PACKETIZER_CONSTS_SVH
`define BUS_PACKETIZER_CONSTS_SVH
`define CTRL_OFS         8'h00
`define IRQ_STAT_OFS     8'h04
`define IRQ_MASK_OFS     8'h08
`define STATE_OFS        8'h0C
`define CTRL_FMT2_BIT    0
`define CTRL_TTP_LSB     1
`define CTRL_FLUSH_BIT   3
`define IRQ_SENT_BIT     0
`define IRQ_FULL_BIT     1
`define STATE_BUSY_BIT   16
`define CTRL_RST         4'h0
`define MASK_RST         2'h0
`define RAM_DEPTH        256
`define F1_HDR_WORDS     3'h7
`define F2_HDR_WORDS     3'h3
`define F1_MAX_WORDS     6'h24
`define F2_XACT_WORDS    6'h06
`define F1_NEED          9'h02B
`define F2_NEED          9'h009
`define F2_LENGTH        16'h0018
`define STAT_XACT_ERR    15
`define STAT_MRST_SEEN   14
`define STAT_TIMEOUT     13
`define STAT_NO_STATUS   6
`define STAT_NO_ECHO     3
`define CSW_TTP_LSB      30
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// file: common/bus_packetizer_pkg.sv
`default_nettype none
package bus_packetizer_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_HDR  = 3'h1,
      ST_BODY = 3'h3,
      ST_FIX  = 3'h2,
      ST_CSW  = 3'h6,
      ST_RD   = 3'h7,
      ST_OUT  = 3'h5
   } pk_state_t;

   typedef struct packed {
      logic        valid;
      logic        last;
      logic [31:0] data;
   } stream_t;

   typedef struct packed {
      logic [47:0] stamp;
      logic [15:0] block_status;
      logic [15:0] gap_times;
      logic        transaction_error_flag;
      logic        master_reset_seen_flag;
      logic        transaction_timeout_flag;
      logic        missing_status_flag;
      logic        missing_echo_flag;
   } msg_meta_t;

   typedef struct packed {
      logic [2:0]  bus_id;
      logic [2:0]  gap_code;
      logic        manchester_err;
      logic        parity_err;
      logic [7:0]  data_hi;
      logic [15:0] data_lo;
   } wb_word_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axi_rsp_t;
endpackage : bus_packetizer_pkg
`default_nettype wire

// file: rtl/packet_ram.sv
`default_nettype none
`include "bus_packetizer_consts.svh"
module packet_ram (
   input  wire logic        i_mclk,   // clock
   input  wire logic        i_we,     // write strobe
   input  wire logic [7:0]  i_waddr,  // write address
   input  wire logic [31:0] i_wdata,  // write data
   input  wire logic [7:0]  i_raddr,  // read address
   output logic      [31:0] o_rdata   // registered read data
);
   logic [31:0] mem [`RAM_DEPTH];

   always_ff @(posedge i_mclk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule : packet_ram
`default_nettype wire

// file: rtl/header_word_sel.sv
`default_nettype none
`include "bus_packetizer_consts.svh"
module header_word_sel (
   input  wire logic                          i_fmt2,  // format 2 packet
   input  wire logic [2:0]                    i_idx,   // header word index
   input  wire bus_packetizer_pkg::msg_meta_t i_meta,  // message meta data
   output logic      [31:0]                   o_word   // header word
);
   import bus_packetizer_pkg::*;
   logic [15:0] status;

   always_comb begin
      // RL11 RL12 RL13 RL15 error bits, reserved zero
      status = 16'h0000;
      status[`STAT_XACT_ERR]  = i_meta.transaction_error_flag;
      status[`STAT_MRST_SEEN] = i_meta.master_reset_seen_flag;
      status[`STAT_TIMEOUT]   = i_meta.transaction_timeout_flag;
      status[`STAT_NO_STATUS] = i_meta.missing_status_flag;
      status[`STAT_NO_ECHO]   = i_meta.missing_echo_flag;
      o_word = 32'h0000_0000;
      if (i_fmt2) begin
         // RL9 RL14 RL16 stamp then header word
         case (i_idx)
            3'h0:    o_word = i_meta.stamp[31:0];
            3'h1:    o_word = {16'h0000, i_meta.stamp[47:32]};
            // RL10 fixed length
            3'h2:    o_word = {`F2_LENGTH, status};
            default: o_word = 32'h0000_0000;
         endcase
      end else begin
         // RL2 RL3 RL17 halves, lowest first
         case (i_idx)
            3'h0:    o_word = {16'h0000, i_meta.stamp[15:0]};
            3'h1:    o_word = {16'h0000, i_meta.stamp[31:16]};
            3'h2:    o_word = {16'h0000, i_meta.stamp[47:32]};
            3'h4:    o_word = {16'h0000, i_meta.block_status};
            3'h5:    o_word = {16'h0000, i_meta.gap_times};
            default: o_word = 32'h0000_0000;
         endcase
      end
   end
endmodule : header_word_sel
`default_nettype wire

// file: rtl/bus_message_packetizer.sv
`default_nettype none
`include "bus_packetizer_consts.svh"
module bus_message_packetizer (
   input  wire logic                          i_mclk,      // 40 MHz clock
   input  wire logic                          i_reset,     // sync reset, high
   input  wire bus_packetizer_pkg::axi_req_t  i_axi,       // register bus request
   output logic                               o_axi_awready,  // aw ready
   output logic                               o_axi_wready,   // w ready
   output logic                               o_axi_bvalid,   // b valid
   output logic      [1:0]                    o_axi_bresp,    // b response
   output logic                               o_axi_arready,  // ar ready
   output logic                               o_axi_rvalid,   // r valid
   output logic      [31:0]                   o_axi_rdata,    // r data
   output logic      [1:0]                    o_axi_rresp,    // r response
   input  wire bus_packetizer_pkg::stream_t   i_in,        // message words in
   input  wire bus_packetizer_pkg::msg_meta_t i_meta,      // meta of next message
   output logic                               o_in_ready,  // word taken
   output bus_packetizer_pkg::stream_t        o_out,       // packet body words
   input  wire logic                          i_out_ready, // consumer ready
   output logic                               o_irq        // interrupt level
);
   import bus_packetizer_pkg::*;

   typedef struct packed {
      pk_state_t   st;
      logic        fmt2;
      logic        ctrl_fmt2;
      logic [1:0]  ttp;
      logic        flush_pend;
      logic [15:0] count;
      logic [8:0]  wptr;
      logic [8:0]  base;
      logic [2:0]  hidx;
      logic [5:0]  wc;
      msg_meta_t   meta;
      logic        csw_idx;
      logic [8:0]  raddr;
      stream_t     out;
      logic        in_ready;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_mask;
      logic        irq;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic        wstrb0;
      axi_rsp_t    rsp;
   } core_state_t;

   core_state_t s_r;
   core_state_t s_nxt;
   logic        mem_we;
   logic [7:0]  mem_waddr;
   logic [31:0] mem_wdata;
   logic [31:0] mem_rdata;
   logic [31:0] hdr_word;
   logic [2:0]  hdr_last;
   logic [8:0]  need;
   logic        wr_take;
   logic        rd_take;
   logic        rd_stat;
   logic [1:0]  ev;
   wb_word_t    wb;

   packet_ram u_ram (
      .i_mclk  (i_mclk),
      .i_we    (mem_we),
      .i_waddr (mem_waddr),
      .i_wdata (mem_wdata),
      .i_raddr (s_r.raddr[7:0]),
      .o_rdata (mem_rdata)
   );

   header_word_sel u_hdr (
      .i_fmt2 (s_r.fmt2),
      .i_idx  (s_r.hidx),
      .i_meta (s_r.meta),
      .o_word (hdr_word)
   );

   always_comb begin
      s_nxt     = s_r;
      mem_we    = 1'b0;
      mem_waddr = s_r.wptr[7:0];
      mem_wdata = hdr_word;
      ev        = 2'b00;
      wb        = wb_word_t'(i_in.data);
      hdr_last  = s_r.fmt2 ? (`F2_HDR_WORDS - 3'h1) : (`F1_HDR_WORDS - 3'h1);
      need      = s_r.ctrl_fmt2 ? `F2_NEED : `F1_NEED;
      wr_take   = 1'b0;
      rd_take   = 1'b0;
      rd_stat   = 1'b0;

      // register bus, write side: address and data in either order
      if (s_r.rsp.bvalid && i_axi.bready) begin
         s_nxt.rsp.bvalid = 1'b0;
      end
      if (s_r.rsp.awready && i_axi.awvalid) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = i_axi.awaddr;
      end
      if (s_r.rsp.wready && i_axi.wvalid) begin
         s_nxt.w_got  = 1'b1;
         s_nxt.wdata  = i_axi.wdata;
         s_nxt.wstrb0 = i_axi.wstrb[0];
      end
      if (s_r.aw_got && s_r.w_got && !s_r.rsp.bvalid) begin
         wr_take          = 1'b1;
         s_nxt.aw_got     = 1'b0;
         s_nxt.w_got      = 1'b0;
         s_nxt.rsp.bvalid = 1'b1;
         s_nxt.rsp.bresp  = `RESP_OKAY;
         case ({s_r.awaddr[7:2], 2'b00})
            `CTRL_OFS: begin
               if (s_r.wstrb0) begin
                  s_nxt.ctrl_fmt2 = s_r.wdata[`CTRL_FMT2_BIT];
                  s_nxt.ttp       = s_r.wdata[`CTRL_TTP_LSB +: 2];
                  if (s_r.wdata[`CTRL_FLUSH_BIT]) begin
                     s_nxt.flush_pend = 1'b1;
                  end
               end
            end
            `IRQ_MASK_OFS: begin
               if (s_r.wstrb0) begin
                  s_nxt.irq_mask = s_r.wdata[1:0];
               end
            end
            `IRQ_STAT_OFS, `STATE_OFS: s_nxt.rsp.bresp = `RESP_OKAY;
            default:                  s_nxt.rsp.bresp = `RESP_SLVERR;
         endcase
      end
      s_nxt.rsp.awready = !s_nxt.aw_got && !s_nxt.rsp.bvalid;
      s_nxt.rsp.wready  = !s_nxt.w_got && !s_nxt.rsp.bvalid;

      // register bus, read side
      if (s_r.rsp.rvalid && i_axi.rready) begin
         s_nxt.rsp.rvalid = 1'b0;
      end
      if (s_r.rsp.arready && i_axi.arvalid) begin
         rd_take          = 1'b1;
         s_nxt.rsp.rvalid = 1'b1;
         s_nxt.rsp.rresp  = `RESP_OKAY;
         s_nxt.rsp.rdata  = 32'h0000_0000;
         case ({i_axi.araddr[7:2], 2'b00})
            `CTRL_OFS: begin
               s_nxt.rsp.rdata[`CTRL_FMT2_BIT]     = s_r.ctrl_fmt2;
               s_nxt.rsp.rdata[`CTRL_TTP_LSB +: 2] = s_r.ttp;
               s_nxt.rsp.rdata[`CTRL_FLUSH_BIT]    = s_r.flush_pend;
            end
            `IRQ_STAT_OFS: begin
               s_nxt.rsp.rdata[1:0] = s_r.irq_stat;
               rd_stat              = 1'b1;
            end
            `IRQ_MASK_OFS: s_nxt.rsp.rdata[1:0] = s_r.irq_mask;
            `STATE_OFS: begin
               s_nxt.rsp.rdata[15:0]            = s_r.count;
               s_nxt.rsp.rdata[`STATE_BUSY_BIT] = (s_r.st != ST_IDLE);
            end
            default: s_nxt.rsp.rresp = `RESP_SLVERR;
         endcase
      end
      s_nxt.rsp.arready = !s_nxt.rsp.rvalid;

      // packet engine
      case (s_r.st)
         ST_IDLE: begin
            s_nxt.in_ready = 1'b0;
            // RL8 close only here, between messages
            if (s_r.flush_pend && s_r.count == 16'h0000) begin
               s_nxt.flush_pend = 1'b0;
            end else if (s_r.flush_pend) begin
               s_nxt.flush_pend = 1'b0;
               s_nxt.csw_idx    = 1'b0;
               s_nxt.st         = ST_CSW;
            end else if (i_in.valid) begin
               if (s_r.count != 16'h0000 && (s_r.wptr + need > 9'(`RAM_DEPTH))) begin
                  // no room for a whole message: close the packet first
                  ev[`IRQ_FULL_BIT] = 1'b1;
                  s_nxt.csw_idx     = 1'b0;
                  s_nxt.st          = ST_CSW;
               end else begin
                  if (s_r.count == 16'h0000) begin
                     s_nxt.fmt2 = s_r.ctrl_fmt2;
                  end
                  s_nxt.meta = i_meta;
                  s_nxt.base = s_r.wptr;
                  s_nxt.hidx = 3'h0;
                  s_nxt.wc   = 6'h00;
                  s_nxt.st   = ST_HDR;
               end
            end
         end
         ST_HDR: begin
            // RL9 header ahead of every message
            mem_we     = 1'b1;
            s_nxt.wptr = s_r.wptr + 9'h001;
            s_nxt.hidx = s_r.hidx + 3'h1;
            if (s_r.hidx == hdr_last) begin
               s_nxt.in_ready = 1'b1;
               s_nxt.st       = ST_BODY;
            end
         end
         ST_BODY: begin
            if (i_in.valid && s_r.in_ready) begin
               mem_we     = 1'b1;
               s_nxt.wptr = s_r.wptr + 9'h001;
               s_nxt.wc   = s_r.wc + 6'h01;
               if (s_r.fmt2) begin
                  // RL19 halves in one word, sync and parity already gone
                  mem_wdata = {wb.bus_id, wb.gap_code, wb.manchester_err,
                               wb.parity_err, wb.data_hi, wb.data_lo};
                  // RL5 RL6 exactly six words, then next transaction
                  if (s_r.wc == `F2_XACT_WORDS - 6'h01) begin
                     s_nxt.in_ready = 1'b0;
                     s_nxt.count    = s_r.count + 16'h0001;
                     s_nxt.st       = ST_IDLE;
                  end
               end else begin
                  // RL4 words kept in bus order, command first
                  mem_wdata = {16'h0000, i_in.data[15:0]};
                  if (i_in.last || s_r.wc == `F1_MAX_WORDS - 6'h01) begin
                     s_nxt.in_ready = 1'b0;
                     s_nxt.st       = ST_FIX;
                  end
               end
            end
         end
         ST_FIX: begin
            // RL17 byte length back into the third header half
            mem_we      = 1'b1;
            mem_waddr   = 8'(s_r.base + 9'(`F1_HDR_WORDS - 3'h1));
            mem_wdata   = {16'h0000, 9'h000, s_r.wc, 1'b0};
            s_nxt.count = s_r.count + 16'h0001;
            s_nxt.st    = ST_IDLE;
         end
         ST_CSW: begin
            if (!s_r.out.valid) begin
               s_nxt.out.valid = 1'b1;
               s_nxt.out.last  = 1'b0;
               if (s_r.fmt2) begin
                  // RL7 16-bit count in bits 15:0, bits 31:16 zero
                  s_nxt.out.data = {16'h0000, s_r.count};
               end else if (!s_r.csw_idx) begin
                  // RL1 RL18 low half first
                  s_nxt.out.data = {16'h0000, s_r.count};
               end else begin
                  // RL15 reserved bits zero
                  s_nxt.out.data = {16'h0000, s_r.ttp, 14'h0000};
               end
            end else if (i_out_ready) begin
               s_nxt.out.valid = 1'b0;
               s_nxt.csw_idx   = 1'b1;
               if (s_r.fmt2 || s_r.csw_idx) begin
                  s_nxt.raddr = 9'h000;
                  s_nxt.st    = ST_RD;
               end
            end
         end
         ST_RD: begin
            // one cycle for the registered ram read
            s_nxt.st = ST_OUT;
         end
         ST_OUT: begin
            if (!s_r.out.valid) begin
               s_nxt.out.valid = 1'b1;
               s_nxt.out.data  = mem_rdata;
               s_nxt.out.last  = (s_r.raddr + 9'h001 == s_r.wptr);
            end else if (i_out_ready) begin
               s_nxt.out.valid = 1'b0;
               s_nxt.out.last  = 1'b0;
               s_nxt.raddr     = s_r.raddr + 9'h001;
               if (s_r.out.last) begin
                  ev[`IRQ_SENT_BIT] = 1'b1;
                  s_nxt.count       = 16'h0000;
                  s_nxt.wptr        = 9'h000;
                  s_nxt.st          = ST_IDLE;
               end else begin
                  s_nxt.st = ST_RD;
               end
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase

      // sticky status: a new event beats the clear-on-read
      s_nxt.irq_stat = (rd_stat ? 2'b00 : s_r.irq_stat) | ev;
      s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         s_r          <= '0;
         s_r.st       <= ST_IDLE;
         s_r.ctrl_fmt2 <= 1'(`CTRL_RST >> `CTRL_FMT2_BIT);
         s_r.ttp       <= 2'(`CTRL_RST >> `CTRL_TTP_LSB);
         s_r.irq_mask <= `MASK_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_axi_awready = s_r.rsp.awready;
   assign o_axi_wready  = s_r.rsp.wready;
   assign o_axi_bvalid  = s_r.rsp.bvalid;
   assign o_axi_bresp   = s_r.rsp.bresp;
   assign o_axi_arready = s_r.rsp.arready;
   assign o_axi_rvalid  = s_r.rsp.rvalid;
   assign o_axi_rdata   = s_r.rsp.rdata;
   assign o_axi_rresp   = s_r.rsp.rresp;
   assign o_in_ready    = s_r.in_ready;
   assign o_out         = s_r.out;
   assign o_irq         = s_r.irq;
endmodule : bus_message_packetizer
`default_nettype wire

// file: tb/bus_message_packetizer_sva.sv
`default_nettype none
module bus_message_packetizer_sva (
   input  wire logic                          i_mclk,         // clock
   input  wire logic                          i_reset,        // sync reset
   input  wire bus_packetizer_pkg::axi_req_t  i_axi,          // bus request
   input  wire logic                          o_axi_awready,  // aw ready
   input  wire logic                          o_axi_wready,   // w ready
   input  wire bus_packetizer_pkg::stream_t   i_in,           // words in
   input  wire logic                          o_in_ready,     // word taken
   input  wire bus_packetizer_pkg::stream_t   o_out,          // words out
   input  wire logic                          i_out_ready,    // consumer ready
   input  wire logic                          o_irq           // interrupt
);
   timeunit 1ns;
   timeprecision 100ps;
   import bus_packetizer_pkg::*;
   logic       fmt_r;
   logic [3:0] tk_r;
   logic [9:0] w_r;
   // format tracked from ctrl writes; bench only changes it between packets
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         fmt_r <= 1'b0;
         tk_r  <= 4'h0;
         w_r   <= 10'h000;
      end else begin
         if (i_axi.awvalid && o_axi_awready && i_axi.wvalid && o_axi_wready && i_axi.awaddr == 8'h00)
            fmt_r <= i_axi.wdata[0];
         tk_r <= o_in_ready ? tk_r + 4'(i_in.valid) : 4'h0;
         if (o_out.valid && i_out_ready)
            w_r <= o_out.last ? 10'h000 : w_r + 10'h001;
      end
   end
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);
   a_out_hold: assert property (o_out.valid && !i_out_ready |=>
      o_out.valid && $stable(o_out.data) && $stable(o_out.last)) else $error("output word changed while stalled");
   a_last_ends: assert property (o_out.valid && o_out.last && i_out_ready |=> !o_out.valid)
      else $error("word offered right after packet end");
   a_no_mix: assert property (o_out.valid |-> !o_in_ready)
      else $error("input accepted while packet emitted");
   a_hdr_before: assert property ($rose(o_in_ready) |-> !$past(o_in_ready, 3))
      else $error("body words accepted without header room");
   a_upper_zero: assert property (!fmt_r && o_out.valid |-> o_out.data[31:16] == 16'h0000)
      else $error("format 1 word has upper half set");
   a_fmt1_end: assert property (!fmt_r && i_in.valid && i_in.last && o_in_ready |=> !o_in_ready)
      else $error("format 1 message not closed at last word");
   a_xact_six: assert property (fmt_r && $fell(o_in_ready) |-> tk_r == 4'h6)
      else $error("format 2 transaction not six words");
   a_whole_xacts: assert property (fmt_r && o_out.valid && o_out.last && i_out_ready |->
      w_r != 10'h000 && w_r % 10'd9 == 10'h000) else $error("format 2 packet holds partial transaction");
   c_pkt_end: cover property (o_out.valid && o_out.last && i_out_ready);
   c_xact: cover property (fmt_r && $fell(o_in_ready));
   c_irq: cover property ($rose(o_irq));
endmodule : bus_message_packetizer_sva
bind bus_message_packetizer bus_message_packetizer_sva chk (
   .i_mclk, .i_reset, .i_axi, .o_axi_awready, .o_axi_wready, .i_in, .o_in_ready, .o_out, .i_out_ready, .o_irq
);
`default_nettype wire

// file: tb/packet_sink.sv
`default_nettype none
module packet_sink import bus_packetizer_pkg::*; (
   input  wire logic                        i_mclk,   // clock
   input  wire logic                        i_reset,  // sync reset
   input  wire bus_packetizer_pkg::stream_t i_word,   // words from block
   input  wire logic                        i_stall,  // throttle on
   output logic                             o_ready   // ready to block
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] got[$];
   int          last_at = -1;
   int          pkts = 0;
   // throttled ready toggles every cycle, as a slow store would
   always @(posedge i_mclk) begin
      if (i_reset) begin
         o_ready <= 1'b0;
      end else begin
         o_ready <= i_stall ? ~o_ready : 1'b1;
         if (i_word.valid && o_ready) begin
            got.push_back(i_word.data);
            if (i_word.last) begin
               last_at = got.size() - 1;
               pkts = pkts + 1;
            end
         end
      end
   end
endmodule : packet_sink
`default_nettype wire

// file: tb/bus_message_packetizer_tb.sv
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module bus_message_packetizer_tb import bus_packetizer_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic        i_mclk, i_reset, stall, out_rdy, awr, wr, bv, arr, rv, irq, in_rdy;
   logic [1:0]  br, rr;
   logic [31:0] rd;
   axi_req_t    req;
   stream_t     inp, outs;
   msg_meta_t   meta;
   logic [31:0] exp_q[$];
   int          num_errors = 0;
   int          samples_checked = 0;
   bus_message_packetizer dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_axi(req), .o_axi_awready(awr),
      .o_axi_wready(wr), .o_axi_bvalid(bv), .o_axi_bresp(br), .o_axi_arready(arr), .o_axi_rvalid(rv),
      .o_axi_rdata(rd), .o_axi_rresp(rr), .i_in(inp), .i_meta(meta), .o_in_ready(in_rdy), .o_out(outs),
      .i_out_ready(out_rdy), .o_irq(irq));
   packet_sink sink (.i_mclk(i_mclk), .i_reset(i_reset), .i_word(outs), .i_stall(stall), .o_ready(out_rdy));
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge i_mclk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      do begin
         @(posedge i_mclk);
         if (awr) req.awvalid <= 1'b0;
         if (wr) req.wvalid <= 1'b0;
      end while (!bv);
      req.bready <= 1'b0;
      `CHK(br, e)
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge i_mclk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge i_mclk);
         if (arr) req.arvalid <= 1'b0;
      end while (!rv);
      req.rready <= 1'b0;
      `CHK(rr, e)
      if (e == 2'h0) `CHK(rd, d)
   endtask : axr
   task automatic msg(input logic f2, input int n, input logic [47:0] st, input logic [4:0] fl);
      int          k;
      logic [31:0] w;
      @(posedge i_mclk);
      meta <= '{st, {12'hB00, 4'(n)}, 16'h0203, fl[4], fl[3], fl[2], fl[1], fl[0]};
      if (f2) begin
         exp_q.push_back(st[31:0]);
         exp_q.push_back({16'h0, st[47:32]});
         exp_q.push_back({16'h0018, fl[4:2], 6'h0, fl[1], 2'h0, fl[0], 3'h0});
      end else begin
         for (k = 0; k < 3; k++) exp_q.push_back(32'(st[16*k +: 16]));
         exp_q.push_back(32'h0);
         exp_q.push_back({20'h0B00, 4'(n)});
         exp_q.push_back(32'h0203);
         exp_q.push_back(32'(2 * n));
      end
      for (k = 0; k < n; k++) begin
         w = f2 ? {3'h7, 3'(k), 1'(k), 1'(k + 1), 8'(k), 16'hC000 + 16'(k)} : {16'hFFFF, 16'h1000 + 16'(k)};
         inp.valid <= 1'b1;
         inp.data <= w;
         // format 2 must ignore a stray last flag mid-transaction
         inp.last <= f2 ? (k == 2) : (k == n - 1);
         exp_q.push_back(f2 ? w : {16'h0, w[15:0]});
         do @(posedge i_mclk); while (!in_rdy);
      end
      inp.valid <= 1'b0;
      repeat (2) @(posedge i_mclk);
   endtask : msg
   task automatic pkt(input logic [3:0] ctrl, input logic [31:0] csw, input logic m);
      int p;
      p = sink.pkts;
      if (ctrl[0]) exp_q.push_front(csw);
      else begin
         exp_q.push_front({16'h0, csw[31:16]});
         exp_q.push_front({16'h0, csw[15:0]});
      end
      axw(8'h00, {28'h0, ctrl | 4'h8}, 2'h0);
      while (sink.pkts == p) @(posedge i_mclk);
      repeat (3) @(posedge i_mclk);
      `CHK(sink.got.size(), exp_q.size())
      foreach (exp_q[i]) `CHK(sink.got[i], exp_q[i])
      `CHK(sink.last_at, exp_q.size() - 1)
      `CHK(irq, m)
      axr(8'h04, 32'h1, 2'h0);
      repeat (3) @(posedge i_mclk);
      `CHK(irq, 1'b0)
      axr(8'h04, 32'h0, 2'h0);
      exp_q.delete();
      sink.got.delete();
      $display("packet test done, format %0d", ctrl[0]);
   endtask : pkt
   task automatic close_out;
      $display("checks made %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   // whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge i_mclk);
      num_errors++;
      close_out();
   end
   initial begin
      i_reset = 1'b1;
      stall = 1'b0;
      req = '0;
      inp = '0;
      meta = '0;
      repeat (3) @(posedge i_mclk);
      i_reset <= 1'b0;
      axr(8'h00, 32'h0, 2'h0);
      axr(8'h08, 32'h0, 2'h0);
      axr(8'h10, 32'h0, 2'h2);
      axw(8'h10, 32'h1, 2'h2);
      $display("register test done");
      axw(8'h00, 32'h4, 2'h0);
      axr(8'h00, 32'h4, 2'h0);
      msg(1'b0, 1, 48'h1234_5678_9ABC, 5'h00);
      msg(1'b0, 3, 48'hFEDC_BA98_7654, 5'h00);
      pkt(4'h4, {2'b10, 6'h0, 24'h2}, 1'b0);
      axw(8'h08, 32'h1, 2'h0);
      axr(8'h08, 32'h1, 2'h0);
      axw(8'h00, 32'h1, 2'h0);
      stall <= 1'b1;
      msg(1'b1, 6, 48'h8000_0000_0001, 5'h15);
      msg(1'b1, 6, 48'h0000_FFFF_0000, 5'h0A);
      msg(1'b1, 6, 48'h0123_4567_89AB, 5'h1F);
      axr(8'h0C, 32'h3, 2'h0);
      pkt(4'h1, 32'h3, 1'b1);
      close_out();
   end
endmodule : bus_message_packetizer_tb
`default_nettype wire
